// File: rtl/slb_lane_ctrl.sv
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module slb_lane_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [7:0] mode_lane_need,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] lane_clk_en,
  output logic [7:0] lane_ser_en,
  output logic [7:0] lane_mode,
  output logic [3:0] lane_test,
  output logic link_encoder_enable
);

  typedef enum {
    BUS_IDLE,
    BUS_ACCESS
  } slb_bus_state_t;

  typedef enum {
    SEL_NONE,
    SEL_SPARE,
    SEL_CTRL,
    SEL_STAT
  } slb_reg_sel_t;

  // lanes enabled up to n must form an unbroken run from lane 0
  function automatic logic [7:0] contiguous(input logic [7:0] en);
    logic [7:0] r;
    r = '0;
    r[0] = en[0];
    for (int i = 1; i < slb_pkg::NUM_LANES; i++) begin
      r[i] = en[i] & r[i-1];
    end
    return r;
  endfunction

  // only the low address bits are decoded, so the map repeats above them
  function automatic slb_reg_sel_t decode_reg(input logic [31:0] addr);
    slb_reg_sel_t sel;
    sel = SEL_NONE;
    case (addr[slb_pkg::ADDR_W-1:0])
      slb_pkg::SPARE_LANE_ADDR: begin
        sel = SEL_SPARE;
      end
      slb_pkg::LINK_CTRL_ADDR: begin
        sel = SEL_CTRL;
      end
      slb_pkg::LANE_STAT_ADDR: begin
        sel = SEL_STAT;
      end
      default: begin
        sel = SEL_NONE;
      end
    endcase
    return sel;
  endfunction

  function automatic logic [7:0] merge_byte(
    input logic [7:0] old_b,
    input logic [7:0] new_b,
    input logic en
  );
    logic [7:0] r;
    r = old_b;
    if (en) begin
      r = new_b;
    end
    return r;
  endfunction

  // a running encoder must not see its lane set change under it, so such
  // writes are dropped and flagged rather than applied late
  function automatic logic write_refused(input slb_reg_sel_t sel, input logic enc_on);
    logic bad;
    bad = 1'b0;
    case (sel)
      SEL_SPARE: begin
        bad = enc_on;
      end
      SEL_CTRL: begin
        bad = 1'b0;
      end
      default: begin
        bad = 1'b1;
      end
    endcase
    return bad;
  endfunction

  function automatic logic [31:0] read_word(
    input slb_reg_sel_t sel,
    input logic [7:0] spare,
    input logic [15:0] ctrl,
    input logic [7:0] clk_en,
    input logic [7:0] ser_en
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    case (sel)
      SEL_SPARE: begin
        w[7:0] = spare;
      end
      SEL_CTRL: begin
        w[15:0] = ctrl;
      end
      SEL_STAT: begin
        w[15:8] = ser_en;
        w[7:0] = clk_en;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  slb_bus_state_t state_q, state_d;
  slb_reg_sel_t sel_q, sel_d;
  logic wr_q, wr_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [7:0] spare_q, spare_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic [31:0] prdata_q, prdata_d;
  logic [7:0] clk_en_q, clk_en_d;
  logic [7:0] ser_en_q, ser_en_d;
  logic [7:0] mode_q, mode_d;
  logic [3:0] test_q, test_d;
  logic enc_q, enc_d;

  logic setup, commit, refuse_now;
  slb_reg_sel_t sel_now;
  logic [7:0] spare_mask, lanes_on, ser_want;

  assign setup = psel & ~penable;
  assign sel_now = decode_reg(paddr);
  assign refuse_now = pwrite ? write_refused(sel_now, ctrl_q[slb_pkg::ENC_EN_BIT])
                             : (sel_now == SEL_NONE);
  // the write lands only at the access edge, where pready is seen high
  assign commit = (state_q == BUS_ACCESS) & psel & penable & wr_q & ~pslverr_q;

  // bus slave: setup is decoded, the answer stands for one access cycle
  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    wr_d = wr_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    case (state_q)
      BUS_IDLE: begin
        if (setup) begin
          state_d = BUS_ACCESS;
          sel_d = sel_now;
          wr_d = pwrite;
          pready_d = 1'b1;
          pslverr_d = refuse_now;
        end
      end
      BUS_ACCESS: begin
        state_d = BUS_IDLE;
      end
      default: begin
        state_d = BUS_IDLE;
      end
    endcase
  end

  always_comb begin
    spare_d = spare_q;
    ctrl_d = ctrl_q;
    if (commit) begin
      case (sel_q)
        SEL_SPARE: begin
          spare_d = merge_byte(spare_q, pwdata[7:0], pstrb[0]);
        end
        SEL_CTRL: begin
          ctrl_d[7:0] = merge_byte(ctrl_q[7:0], pwdata[7:0], pstrb[0]);
          ctrl_d[15:8] = merge_byte(ctrl_q[15:8], pwdata[15:8], pstrb[1]);
        end
        default: begin
          spare_d = spare_q;
        end
      endcase
    end
  end

  // read data is held until the next read, unmapped reads give zero
  always_comb begin
    prdata_d = prdata_q;
    if ((state_q == BUS_IDLE) && setup && !pwrite) begin
      prdata_d = read_word(sel_now, spare_q, ctrl_q, clk_en_q, ser_en_q);
    end
  end

  // lane enables; the mask covers lanes 1..7, lane 0 is driven by the mode only
  always_comb begin
    spare_mask = {spare_q[slb_pkg::MASK_MSB:slb_pkg::MASK_LSB], 1'b0};
    lanes_on = mode_lane_need | spare_mask;
    clk_en_d = '0;
    ser_en_d = '0;
    if (ctrl_q[slb_pkg::ENC_EN_BIT] && !ctrl_q[slb_pkg::PD_B_BIT]) begin
      clk_en_d = lanes_on;
      if (spare_q[slb_pkg::SER_ON_BIT]) begin
        ser_want = lanes_on;
      end else begin
        ser_want = mode_lane_need;
      end
      ser_en_d = contiguous(ser_want);
    end else begin
      ser_want = '0;
    end
    // rate and pattern follow the link settings only
    mode_d = ctrl_q[slb_pkg::MODE_MSB:slb_pkg::MODE_LSB];
    test_d = ctrl_q[slb_pkg::TEST_MSB:slb_pkg::TEST_LSB];
    enc_d = ctrl_q[slb_pkg::ENC_EN_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= BUS_IDLE;
      sel_q <= SEL_NONE;
      wr_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      wr_q <= wr_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spare_q <= slb_pkg::SPARE_LANE_RST;
      ctrl_q <= slb_pkg::LINK_CTRL_RST;
    end else begin
      spare_q <= spare_d;
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_en_q <= 8'h00;
      ser_en_q <= 8'h00;
      mode_q <= 8'h00;
      test_q <= 4'h0;
      enc_q <= 1'b0;
    end else begin
      clk_en_q <= clk_en_d;
      ser_en_q <= ser_en_d;
      mode_q <= mode_d;
      test_q <= test_d;
      enc_q <= enc_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign lane_clk_en = clk_en_q;
  assign lane_ser_en = ser_en_q;
  assign lane_mode = mode_q;
  assign lane_test = test_q;
  assign link_encoder_enable = enc_q;

endmodule

// File: rtl/slb_pkg.sv
package slb_pkg;
  // register indices; printed offsets are not word aligned, byte address = 4 * index
  localparam logic [11:0] SPARE_LANE_IDX = 12'h020B;
  localparam logic [11:0] LINK_CTRL_IDX = 12'h0300;
  localparam logic [11:0] LANE_STAT_IDX = 12'h0301;
  localparam int ADDR_W = 14;
  localparam logic [ADDR_W-1:0] SPARE_LANE_ADDR = {SPARE_LANE_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] LINK_CTRL_ADDR = {LINK_CTRL_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] LANE_STAT_ADDR = {LANE_STAT_IDX, 2'b00};
  // spare lane register fields
  localparam int SER_ON_BIT = 0;
  localparam int MASK_LSB = 1;
  localparam int MASK_MSB = 7;
  localparam logic [7:0] SPARE_LANE_RST = 8'h00;
  // link control register fields
  localparam int ENC_EN_BIT = 0;
  localparam int PD_B_BIT = 1;
  localparam int TEST_LSB = 4;
  localparam int TEST_MSB = 7;
  localparam int MODE_LSB = 8;
  localparam int MODE_MSB = 15;
  localparam logic [15:0] LINK_CTRL_RST = 16'h0000;
  localparam int NUM_LANES = 8;
  localparam int MODE_W = 8;
  localparam int TEST_W = 4;
endpackage

// File: tb/slb_chk_sva.sv
`timescale 1ns/100ps
module slb_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] lane_clk_en,
  input wire logic [7:0] lane_ser_en,
  input wire logic link_encoder_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ser_in_clk_a: assert property ((lane_ser_en & ~lane_clk_en) == 8'h00) else $error("ser off clk");
  ser_prefix_a: assert property (((lane_ser_en + 8'h01) & lane_ser_en) == 8'h00) else $error("gap");
  enc_gate_a: assert property (!link_encoder_enable |-> lane_clk_en == 8'h00) else $error("enc");
  reg_answer_a: assert property (psel && !penable |=> pready) else $error("no ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("err alone");
  rst_idle_a: assert property ($rose(presetn) |-> lane_clk_en == 8'h00) else $error("rst");
  cover property (lane_ser_en[0]);
  cover property (pslverr);
  cover property (lane_clk_en != 8'h00 && lane_ser_en == 8'h00);
endmodule
bind slb_lane_ctrl slb_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .lane_clk_en(lane_clk_en), .lane_ser_en(lane_ser_en),
  .link_encoder_enable(link_encoder_enable));

// File: tb/slb_rx_model.sv
`timescale 1ns/100ps
module slb_rx_model (
  input wire logic pclk,
  input wire logic [7:0] lane_ser_en,
  output logic [7:0] lanes_up
);
  // a lane counts as up one cycle after its serializer starts sending
  always_ff @(posedge pclk) lanes_up <= lane_ser_en;
endmodule

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, pready, pslverr;
  logic [31:0] paddr = 0, pwdata = 0, prdata, r;
  logic [7:0] need = 0, nd, s, clk_en, ser_en, up, mode;
  logic [15:0] c, e;
  logic [3:0] test;
  int fail_count = 0, num_checks = 0, cyc = 0, i;
  integer seed = 32'h5108;
  always #5 pclk = ~pclk;
  slb_lane_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .mode_lane_need(need),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lane_clk_en(clk_en),
    .lane_ser_en(ser_en), .lane_mode(mode), .lane_test(test), .link_encoder_enable());
  slb_rx_model rx (.pclk(pclk), .lane_ser_en(ser_en), .lanes_up(up));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= {18'h0_0000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(negedge pclk);
    while (pready !== 1'b1) @(negedge pclk);
    r = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  // lanes 0..n-1 must all be on before serializer n is enabled
  function automatic logic [15:0] expf(input logic [7:0] sp, input logic [7:0] n,
      input logic [15:0] cf);
    logic [7:0] w, q, p;
    w = n | {sp[7:1], 1'b0};
    q = sp[0] ? w : n;
    p = 8'h00;
    for (int k = 0; k < 8 && q[k]; k++) p[k] = 1'b1;
    return (cf[0] && !cf[1]) ? {p, w} : 16'h0000;
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, slb_pkg::SPARE_LANE_ADDR, 0);
    chk(r, {24'h00_0000, slb_pkg::SPARE_LANE_RST});
    apb(0, 14'h3FFC, 0);
    chk({err, r[30:0]}, 32'h8000_0000);
    for (i = 0; i < 24; i++) begin
      {nd, s, c} = {$random(seed)};
      case (i)
        0: {nd, s, c} = 32'h00FF_0001;
        1: {nd, s, c} = 32'h0107_0001;
        2: {nd, s, c} = 32'hFF0F_0003;
        default: ;
      endcase
      need <= nd;
      apb(1, slb_pkg::LINK_CTRL_ADDR, 0);
      apb(1, slb_pkg::SPARE_LANE_ADDR, {24'h00_0000, s});
      apb(1, slb_pkg::LINK_CTRL_ADDR, {16'h0000, c});
      apb(1, slb_pkg::SPARE_LANE_ADDR, {24'h00_0000, ~s});
      chk({31'h0000_0000, err}, {31'h0000_0000, c[0]});
      if (!c[0]) s = ~s;
      e = expf(s, nd, c);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk({8'h00, up, ser_en, clk_en}, {8'h00, e[15:8], e});
      chk({20'h0_0000, mode, test}, {20'h0_0000, c[15:4]});
      apb(0, slb_pkg::SPARE_LANE_ADDR, 0);
      chk(r, {24'h00_0000, s});
    end
    $display("lane mask test done");
    complete_run;
  end
endmodule
